// ==== logic/bstre_pkg.sv ====
package bstre_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int DATA_W    = 8;
  localparam int ROM_W     = 15;
  localparam int ADDR_W    = 12;
  localparam int PAGE_W    = ADDR_W - DATA_W;
  localparam int HIGH_W    = ROM_W - DATA_W;
  localparam int RAM_AW    = 8;
  localparam int BITSEL_W  = 3;

  // ----------------------------------------------------------------
  // Reset values, last page and cycle counts
  // ----------------------------------------------------------------
  localparam logic [HIGH_W-1:0] HIGH_RESET   = 7'h00;
  localparam logic [PAGE_W-1:0] LAST_PAGE    = 4'hF;
  localparam int                SKIP_CYCLES  = 2;
  localparam int                PLAIN_CYCLES = 1;

  // ----------------------------------------------------------------
  // Instruction selection
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    BSTRE_OP_SKIP_BIT_CLEAR,
    BSTRE_OP_TABLE_READ_CURRENT,
    BSTRE_OP_TABLE_READ_LAST,
    BSTRE_OP_OTHER
  } bstre_op_type;

  typedef struct packed {
    logic                valid;
    bstre_op_type        op;
    logic [RAM_AW-1:0]   addr;
    logic [BITSEL_W-1:0] bitSel;
  } bstre_instr_type;

  typedef struct packed {
    logic              en;
    logic [RAM_AW-1:0] addr;
    logic [DATA_W-1:0] data;
  } bstre_ram_write_type;

endpackage : bstre_pkg

// ==== logic/bstre_exec.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// RULE1 - Skip test reads the chosen bit of the addressed byte; skips on zero.
// RULE2 - Taken skip flushes the prefetched instruction and adds a dummy cycle.
// RULE3 - Bit set: carry on sequentially, nothing flushed, one cycle.
// RULE4 - Current-page read: present page plus pointer; low byte to memory.
// RULE5 - Last-page read: final page plus pointer; low byte to memory.
// RULE6 - Both table reads load the word's upper part into the high-byte latch.
// RULE7 - None of the three instructions touches any status flag.
module bstre_exec (
  input  wire logic                           clk_sys,
  input  wire logic                           resetn,
  input  wire bstre_pkg::bstre_instr_type     instr,
  input  wire logic [bstre_pkg::DATA_W-1:0]   ramReadData,
  input  wire logic [bstre_pkg::ADDR_W-1:0]   progCounter,
  input  wire logic [bstre_pkg::DATA_W-1:0]   table_pointer,
  input  wire logic [bstre_pkg::ROM_W-1:0]    romData,
  output logic [bstre_pkg::ADDR_W-1:0]        romAddr,
  output logic                                romReq,
  output bstre_pkg::bstre_ram_write_type      ramWrite,
  output logic [bstre_pkg::HIGH_W-1:0]        table_high_byte_latch,
  output logic                                flushPrefetch,
  output logic                                dummyCycle,
  output logic                                busy,
  output logic                                flagWriteEn
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {IDLE, DUMMY, TABLE} bstre_state_type;

  bstre_state_type   state;
  bstre_state_type   next_state;
  logic              bitClear;
  logic              isSkip;
  logic              isRead;
  logic [bstre_pkg::RAM_AW-1:0] destAddr;

  function automatic logic [bstre_pkg::ADDR_W-1:0] table_addr(
    input logic [bstre_pkg::PAGE_W-1:0] page,
    input logic [bstre_pkg::DATA_W-1:0] ptr
  );
    table_addr = {page, ptr};
  endfunction : table_addr

  // Instruction is ignored while a dummy or table cycle is in flight
  assign isSkip = instr.valid && (state == IDLE)
    && (instr.op == bstre_pkg::BSTRE_OP_SKIP_BIT_CLEAR);
  assign isRead = instr.valid && (state == IDLE)
    && ((instr.op == bstre_pkg::BSTRE_OP_TABLE_READ_CURRENT)
    || (instr.op == bstre_pkg::BSTRE_OP_TABLE_READ_LAST));
  assign bitClear = ~ramReadData[instr.bitSel]; // RULE1

  always_comb begin
    next_state = state;
    unique case (state)
      IDLE: begin
        if (isSkip && bitClear) begin
          next_state = DUMMY; // RULE2
        end else if (isRead) begin
          next_state = TABLE;
        end
      end
      DUMMY: next_state = IDLE;
      TABLE: next_state = IDLE;
      // The fourth code of the state word is unused
      default: next_state = IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      state <= IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Skip handling
  // ----------------------------------------------------------------
  // Flush is combinational so the fetch unit drops the word this cycle;
  // a set bit leaves both low and the instruction ends in one cycle.
  assign flushPrefetch = isSkip && bitClear; // RULE2 RULE3
  assign dummyCycle    = (state == DUMMY); // RULE2
  assign busy          = (state != IDLE);
  assign flagWriteEn   = 1'b0; // RULE7

  // ----------------------------------------------------------------
  // Table read
  // ----------------------------------------------------------------
  always_comb begin
    romReq  = isRead;
    romAddr = '0;
    if (isRead) begin
      if (instr.op == bstre_pkg::BSTRE_OP_TABLE_READ_LAST) begin
        romAddr = table_addr(bstre_pkg::LAST_PAGE, table_pointer); // RULE5
      end else begin
        romAddr = table_addr(
          progCounter[bstre_pkg::ADDR_W-1:bstre_pkg::DATA_W],
          table_pointer); // RULE4
      end
    end
  end

  // Destination is held because the ROM answers one cycle later
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      destAddr <= '0;
    end else if (isRead) begin
      destAddr <= instr.addr;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      ramWrite <= '0;
    end else begin
      ramWrite.en   <= (state == TABLE);
      ramWrite.addr <= destAddr;
      ramWrite.data <= romData[bstre_pkg::DATA_W-1:0]; // RULE4 RULE5
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      table_high_byte_latch <= bstre_pkg::HIGH_RESET;
    end else if (state == TABLE) begin
      table_high_byte_latch <=
        romData[bstre_pkg::ROM_W-1:bstre_pkg::DATA_W]; // RULE6
    end
  end

endmodule : bstre_exec

// ==== testbench/bstre_exec_chk.sv ====
`timescale 1ns/1ps
module bstre_exec_chk (
  input logic clk_sys,
  input logic resetn,
  input bstre_pkg::bstre_instr_type instr,
  input logic [7:0] ramReadData,
  input logic [11:0] progCounter,
  input logic [7:0] table_pointer,
  input logic [14:0] romData,
  input logic [11:0] romAddr,
  input logic romReq,
  input bstre_pkg::bstre_ram_write_type ramWrite,
  input logic [6:0] table_high_byte_latch,
  input logic flushPrefetch,
  input logic dummyCycle,
  input logic busy,
  input logic flagWriteEn
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  wire tk = instr.valid && !busy;
  wire [1:0] op = instr.op;
  wire bt = ramReadData[instr.bitSel];
  a_skip_taken: assert property (tk && op == 2'h0 && !bt |->
    flushPrefetch ##1 dummyCycle && busy) else $error("skip");
  a_skip_plain: assert property (tk && op == 2'h0 && bt |->
    !flushPrefetch ##1 !dummyCycle) else $error("no skip");
  a_dummy_once: assert property (dummyCycle |=> !dummyCycle)
    else $error("dummy");
  a_page_now: assert property (tk && op == 2'h1 |-> romReq &&
    romAddr == {progCounter[11:8], table_pointer}) else $error("cur");
  a_page_last: assert property (tk && op == 2'h2 |-> romReq &&
    romAddr == {bstre_pkg::LAST_PAGE, table_pointer}) else $error("last");
  a_low_write: assert property (romReq |-> ##2 ramWrite.en &&
    ramWrite.data == $past(romData[7:0])) else $error("low");
  a_high_latch: assert property (romReq |-> ##2
    table_high_byte_latch == $past(romData[14:8])) else $error("high");
  a_flags_kept: assert property (!flagWriteEn) else $error("flag");
  c_taken: cover property (flushPrefetch);
  c_plain: cover property (tk && op == 2'h0 && bt);
  c_table: cover property (ramWrite.en);
endmodule : bstre_exec_chk
bind bstre_exec bstre_exec_chk u_chk (.*);

// ==== testbench/bstre_rom_model.sv ====
`timescale 1ns/1ps
module bstre_rom_model (
  input logic clk_sys,
  input logic romReq,
  input logic [11:0] romAddr,
  output logic [14:0] romData = 15'h1234
);
  // Word is valid only in the cycle after a request; it toggles after that
  always @(posedge clk_sys) begin
    romData <= romReq ? {romAddr[10:4], romAddr[7:0]} ^ 15'h5A3C : ~romData;
  end
endmodule : bstre_rom_model

// ==== testbench/tb_bit_skip_table_read_exec.sv ====
`timescale 1ns/1ps
module tb_bit_skip_table_read_exec;
  logic clk_sys = '0, resetn = '0, romReq, flushPrefetch, dummyCycle, busy, fw;
  bstre_pkg::bstre_instr_type in = '0;
  bstre_pkg::bstre_ram_write_type rw;
  logic [7:0] rd = '0, tp = '0;
  logic [11:0] pc = '0, ra, a;
  logic [14:0] rom, w;
  logic [6:0] hb, lat = '0;
  int n_errors = 0, samples_checked = 0, seed = 27;
  initial forever #12.5 clk_sys = ~clk_sys;
  bstre_exec u_dut (.clk_sys, .resetn, .instr(in), .ramReadData(rd),
    .progCounter(pc), .table_pointer(tp), .romData(rom), .romAddr(ra),
    .romReq, .ramWrite(rw), .table_high_byte_latch(hb), .flushPrefetch,
    .dummyCycle, .busy, .flagWriteEn(fw));
  bstre_rom_model u_rom (.clk_sys, .romReq, .romAddr(ra), .romData(rom));
  task automatic chk(input logic [15:0] s, e);
    samples_checked++;
    if (s !== e) begin
      n_errors++;
      $display("ERROR %0t seen %h exp %h", $time, s, e);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (20) @(negedge clk_sys);
    resetn = 1'h1;
    // All four op codes and every bit position come from the random word
    repeat (80) begin
      @(negedge clk_sys);
      {rd, tp, pc} = 28'($random(seed));
      in = '{1'h1, bstre_pkg::bstre_op_type'(2'($random(seed))), pc[7:0],
        tp[2:0]};
      a = {in.op == 2'h2 ? bstre_pkg::LAST_PAGE : pc[11:8], tp};
      w = {a[10:4], a[7:0]} ^ 15'h5A3C;
      if (in.op inside {2'h1, 2'h2}) lat = w[14:8];
      #1 chk(flushPrefetch, in.op == 2'h0 && !rd[in.bitSel]);
      chk(romReq, in.op inside {2'h1, 2'h2});
      if (romReq) chk(ra, a);
      // Request held on into the next cycle: refused if busy, otherwise it neither flushes nor fetches
      @(negedge clk_sys);
      #1 chk(dummyCycle, in.op == 2'h0 && !rd[in.bitSel]);
      chk(busy, in.op inside {2'h1, 2'h2}
        || (in.op == 2'h0 && !rd[in.bitSel]));
      chk({flushPrefetch, romReq}, 2'h0);
      @(negedge clk_sys);
      in.valid = 1'h0;
      chk(rw.en, in.op inside {2'h1, 2'h2});
      if (rw.en) chk({rw.addr, rw.data}, {in.addr, w[7:0]});
      chk(hb, lat);
      chk(fw, 1'h0);
    end
    // Mid-run reset clears the latch and the write strobe
    resetn = 1'h0;
    repeat (2) @(negedge clk_sys);
    chk({rw.en, hb}, 8'h00);
    resetn = 1'h1;
    @(negedge clk_sys);
    chk({busy, dummyCycle}, 2'h0);
    tally_and_finish();
  end
endmodule : tb_bit_skip_table_read_exec
